// file: rtl/brg_pkg.sv
// Shared constants and state types for the baud rate unit and its controller
package brg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Link register port of the baud rate unit
   localparam int             DATA_W          = 8;
   localparam int             ADDR_W          = 3;
   localparam int             PRESC_W         = 4;
   localparam logic [2:0]     ADDR_CTRL       = 3'h3;
   localparam logic [2:0]     ADDR_COUNT      = 3'h4;
   localparam logic [2:0]     ADDR_RELOAD     = 3'h5;

   // Control register layout; bits 7..5 are reserved and read as zero
   localparam int             CTL_SEL_LSB     = 0;
   localparam int             CTL_RUN_BIT     = 2;
   localparam int             CTL_FLAG_BIT    = 3;
   localparam int             CTL_MODE_BIT    = 4;

   localparam logic [7:0]     COUNT_RST       = 8'h00;
   localparam logic [7:0]     RELOAD_RST      = 8'h00;
   localparam logic [7:0]     CTRL_RST        = 8'h00;
   localparam logic [7:0]     COUNT_TOP       = 8'hff;

   // Last baud tick count of a bit; serial port samples each bit over sixteen baud ticks
   localparam logic [3:0]     OVERSAMPLE_LAST = 4'hf;

   ////////////////////////////////////////////////////////////////////////////////
   // Controller registers, Avalon word addresses
   localparam int             AV_ADDR_W       = 3;
   localparam logic [2:0]     CR_CMD          = 3'h0;
   localparam logic [2:0]     CR_CFG          = 3'h1;
   localparam logic [2:0]     CR_STATUS       = 3'h2;
   localparam logic [2:0]     CR_MASK         = 3'h3;
   localparam logic [2:0]     CR_BITS         = 3'h4;
   localparam logic [2:0]     CR_SNAP         = 3'h5;

   localparam int             CMD_START       = 0;
   localparam int             CMD_STOP        = 1;
   localparam int             CMD_SNAP        = 2;
   localparam int             CMD_TIMER       = 3;

   localparam int             CFG_N_LSB       = 8;
   localparam logic [2:0]     CFG_N_RST       = 3'h1;
   localparam logic [2:0]     N_MIN           = 3'h1;
   localparam logic [2:0]     N_MAX           = 3'h4;

   localparam int             ST_W            = 4;
   localparam int             ST_DONE         = 0;
   localparam int             ST_BIT          = 1;
   localparam int             ST_OVF          = 2;
   localparam int             ST_BADCFG       = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // State types
   typedef enum logic [2:0] {
      CS_IDLE      = 3'b000,
      CS_LOAD_RLD  = 3'b001,
      CS_START     = 3'b010,
      CS_CLR       = 3'b011,
      CS_READ_WAIT = 3'b100
   } brg_ctl_fsm_t;

   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic [7:0]         count;
      logic [7:0]         reload;
      logic [1:0]         sel;
      logic               run;
      logic               flag;
      logic               mode;
      logic               baud_tick;
      logic               ovf;
      logic [7:0]         rdata;
      logic               rvalid;
   } brg_dev_state_t;

endpackage : brg_pkg

// file: rtl/brg_link_if.sv
// Link between the baud rate unit and its controller / serial port side
`timescale 1ns/1ps
interface brg_link_if;
   import brg_pkg::*;

   logic [ADDR_W-1:0] reg_addr;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_wdata;
   logic [7:0]        reg_rdata;
   logic              reg_rvalid;
   logic              baud_tick;
   logic              irq;

   modport dev (
      input  reg_addr,
      input  reg_wr,
      input  reg_rd,
      input  reg_wdata,
      output reg_rdata,
      output reg_rvalid,
      output baud_tick,
      output irq
   );

   modport ctl (
      output reg_addr,
      output reg_wr,
      output reg_rd,
      output reg_wdata,
      input  reg_rdata,
      input  reg_rvalid,
      input  baud_tick,
      input  irq
   );

endinterface : brg_link_if

// file: rtl/brg_device.sv
// Baud rate unit: 8-bit auto-reload counter with prescaler and overflow flag
//
// What this block does
// [R01] Counter ticks; overflow gives request, and baud pulse in mode one
// [R02] Overflow reloads counter, keeps counting alone
// [R03] Registers reset to zero: divide-by-2, stopped
// [R04] Select field picks 2, 4, 8, 16 clocks
// [R05] Counts only while run bit is one
// [R06] Overflow flag sticky, cleared by writing one
// [R07] Mode one gives baud clock; zero timer only
// [R08] Baud equals clock over 16*2^n*(256-D)
// [R09] Software keeps n in 1..4, D 0..255
// [R10] Software loads D to counter and reload first
// [R11] Software writes n minus one to select
// [R12] Run and mode set in one write
// [R13] Reserved control bits always written zero
// [R14] Tick is enable pulse from free prescaler
// [R15] Counter write beats same-cycle increment or reload
`timescale 1ns/1ps
module brg_device (
   input  logic       core_clk,
   input  logic       rst_b,
   brg_link_if.dev    link,
   output logic       timer_ovf,
   output logic [7:0] count_now
);
   import brg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (DATA_W != 8) begin : g_width_check
      $error("brg_device serves an 8-bit counter only");
   end
   if (PRESC_W < 4) begin : g_presc_check
      $error("brg_device prescaler must reach divide by 16");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Low prescaler bits that must all be one for a tick at the chosen rate
   function automatic logic [PRESC_W-1:0] tick_mask(input logic [1:0] sel);
      logic [PRESC_W-1:0] m;
      m = '0;
      case (sel)
         2'h0:    m[0:0] = 1'h1;
         2'h1:    m[1:0] = 2'h3;
         2'h2:    m[2:0] = 3'h7;
         2'h3:    m[3:0] = 4'hf;
         default: m[0:0] = 1'h1;
      endcase
      return m;
   endfunction : tick_mask

   // Control register as software sees it; reserved bits read zero
   function automatic logic [7:0] ctrl_image(input brg_dev_state_t st);
      logic [7:0] v;
      v = 8'h00;
      v[CTL_SEL_LSB +: 2] = st.sel;
      v[CTL_RUN_BIT]      = st.run;
      v[CTL_FLAG_BIT]     = st.flag;
      v[CTL_MODE_BIT]     = st.mode;
      return v;
   endfunction : ctrl_image

   ////////////////////////////////////////////////////////////////////////////////
   // State

   brg_dev_state_t     s;
   brg_dev_state_t     next_s;
   logic               tick;
   logic               wrap;
   logic               wr_count;
   logic               wr_reload;
   logic               wr_ctrl;
   logic [PRESC_W-1:0] mask;

   always_comb begin
      next_s   = s;
      mask     = tick_mask(s.sel);
      // Prescaler runs freely so the first tick after start lands anywhere
      // inside one prescale period; the period itself is exact
      next_s.presc     = s.presc + {{(PRESC_W-1){1'b0}}, 1'b1};     // [R14]
      tick             = ((s.presc & mask) == mask);                // [R04] [R14]
      wrap             = 1'b0;
      next_s.baud_tick = 1'b0;
      next_s.ovf       = 1'b0;
      next_s.rvalid    = 1'b0;
      wr_count  = link.reg_wr && (link.reg_addr == ADDR_COUNT);
      wr_reload = link.reg_wr && (link.reg_addr == ADDR_RELOAD);
      wr_ctrl   = link.reg_wr && (link.reg_addr == ADDR_CTRL);

      ////////////////////////////////////////////////////////////////////////////////
      // Counting
      if (s.run && tick) begin                                       // [R05]
         if (s.count == COUNT_TOP) begin
            wrap           = 1'b1;
            next_s.count   = s.reload;                               // [R02]
         end else begin
            next_s.count   = s.count + 8'h01;                        // [R01]
         end
      end
      if (wrap) begin
         next_s.ovf       = 1'b1;                                    // [R01]
         // One tick per overflow; period is 2^n * (256 - D) clocks
         next_s.baud_tick = s.mode;                                  // [R07] [R08]
      end

      ////////////////////////////////////////////////////////////////////////////////
      // Register writes
      if (wr_count) begin
         next_s.count = link.reg_wdata;                              // [R15]
      end
      if (wr_reload) begin
         next_s.reload = link.reg_wdata;
      end
      if (wr_ctrl) begin
         next_s.sel  = link.reg_wdata[CTL_SEL_LSB +: 2];             // [R04]
         next_s.run  = link.reg_wdata[CTL_RUN_BIT];                  // [R05]
         next_s.mode = link.reg_wdata[CTL_MODE_BIT];                 // [R07]
         if (link.reg_wdata[CTL_FLAG_BIT]) begin
            next_s.flag = 1'b0;                                      // [R06]
         end
      end
      // An overflow in the clearing cycle is kept
      if (wrap) begin
         next_s.flag = 1'b1;                                         // [R06]
      end

      ////////////////////////////////////////////////////////////////////////////////
      // Register reads, answered one cycle later
      if (link.reg_rd) begin
         next_s.rvalid = 1'b1;
         case (link.reg_addr)
            ADDR_CTRL:   next_s.rdata = ctrl_image(s);
            ADDR_COUNT:  next_s.rdata = s.count;
            ADDR_RELOAD: next_s.rdata = s.reload;
            default:     next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s.presc     <= '0;
         s.count     <= COUNT_RST;                                   // [R03]
         s.reload    <= RELOAD_RST;                                  // [R03]
         s.sel       <= CTRL_RST[CTL_SEL_LSB +: 2];                  // [R03]
         s.run       <= CTRL_RST[CTL_RUN_BIT];                       // [R03]
         s.flag      <= CTRL_RST[CTL_FLAG_BIT];
         s.mode      <= CTRL_RST[CTL_MODE_BIT];
         s.baud_tick <= 1'b0;
         s.ovf       <= 1'b0;
         s.rdata     <= 8'h00;
         s.rvalid    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from state flops

   assign link.baud_tick  = s.baud_tick;
   assign link.irq        = s.flag;                                  // [R01] [R06]
   assign link.reg_rdata  = s.rdata;
   assign link.reg_rvalid = s.rvalid;
   assign timer_ovf       = s.ovf;
   assign count_now       = s.count;

endmodule : brg_device

// file: rtl/brg_ctrl.sv
// Controller end: programs the baud rate unit, divides baud ticks to bit times
`timescale 1ns/1ps
module brg_ctrl #(
   parameter int BITS_W = 16
) (
   input  logic                          core_clk,
   input  logic                          rst_b,
   input  logic [brg_pkg::AV_ADDR_W-1:0] avs_address,
   input  logic                          avs_read,
   input  logic                          avs_write,
   input  logic [31:0]                   avs_writedata,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   output logic                          irq,
   output logic                          bit_strobe,
   brg_link_if.ctl                       link
);
   import brg_pkg::*;

   if (BITS_W < 1 || BITS_W > 32) begin : g_bits_check
      $error("brg_ctrl BITS_W must be 1..32");
   end

   typedef struct packed {
      brg_ctl_fsm_t      fsm;
      logic [7:0]        cfg_d;
      logic [2:0]        cfg_n;
      logic [7:0]        ctrl_copy;
      logic              pend_start;
      logic              pend_timer;
      logic              pend_stop;
      logic              pend_snap;
      logic [ST_W-1:0]   status;
      logic [ST_W-1:0]   mask;
      logic              irq;
      logic [3:0]        sub;
      logic [BITS_W-1:0] bits;
      logic              bit_strobe;
      logic [7:0]        snap;
      logic              wait_r;
      logic [31:0]       rdata;
      logic [2:0]        l_addr;
      logic              l_wr;
      logic              l_rd;
      logic [7:0]        l_wdata;
   } brg_ctl_state_t;

   brg_ctl_state_t s;
   brg_ctl_state_t next_s;
   logic           take;
   logic [ST_W-1:0] set_ev;

   always_comb begin
      next_s            = s;
      set_ev            = '0;
      next_s.l_wr       = 1'b0;
      next_s.l_rd       = 1'b0;
      next_s.bit_strobe = 1'b0;
      take              = (avs_read || avs_write) && !s.wait_r;

      ////////////////////////////////////////////////////////////////////////////////
      // Avalon slave: one wait state, action at the edge where waitrequest is low
      next_s.wait_r = 1'b1;
      if ((avs_read || avs_write) && s.wait_r) begin
         next_s.wait_r = 1'b0;
         case (avs_address)
            CR_CFG:    next_s.rdata = {21'h0, s.cfg_n, s.cfg_d};
            CR_STATUS: next_s.rdata = {{(32-ST_W){1'b0}}, s.status};
            CR_MASK:   next_s.rdata = {{(32-ST_W){1'b0}}, s.mask};
            CR_BITS:   next_s.rdata = {{(32-BITS_W){1'b0}}, s.bits};
            CR_SNAP:   next_s.rdata = {24'h0, s.snap};
            default:   next_s.rdata = 32'h0;
         endcase
      end
      if (take && avs_write) begin
         case (avs_address)
            CR_CMD: begin
               next_s.pend_start = s.pend_start | avs_writedata[CMD_START];
               next_s.pend_timer = s.pend_timer | avs_writedata[CMD_TIMER];
               next_s.pend_stop  = s.pend_stop | avs_writedata[CMD_STOP];
               next_s.pend_snap  = s.pend_snap | avs_writedata[CMD_SNAP];
            end
            CR_CFG: begin
               next_s.cfg_d = avs_writedata[7:0];
               next_s.cfg_n = avs_writedata[CFG_N_LSB +: 3];
            end
            CR_STATUS: next_s.status = s.status & ~avs_writedata[ST_W-1:0];
            CR_MASK:   next_s.mask   = avs_writedata[ST_W-1:0];
            default:   next_s.rdata  = s.rdata;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////////
      // Baud ticks: sixteen of them make one bit time
      if (link.baud_tick) begin
         next_s.sub = s.sub + 4'h1;
         if (s.sub == OVERSAMPLE_LAST) begin                          // [R08]
            next_s.bits       = s.bits + {{(BITS_W-1){1'b0}}, 1'b1};
            next_s.bit_strobe = 1'b1;
            set_ev[ST_BIT]    = 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////////////////
      // Programming sequence
      case (s.fsm)
         CS_IDLE: begin
            if (link.irq) begin
               // Flag write keeps run, mode and select as last written
               next_s.l_addr  = ADDR_CTRL;
               next_s.l_wr    = 1'b1;
               next_s.l_wdata = s.ctrl_copy | (8'h01 << CTL_FLAG_BIT);
               set_ev[ST_OVF] = 1'b1;
               next_s.fsm     = CS_CLR;
            end else if (s.pend_stop) begin
               next_s.pend_stop = 1'b0;
               next_s.ctrl_copy = s.ctrl_copy & ~(8'h01 << CTL_RUN_BIT);
               next_s.l_addr    = ADDR_CTRL;
               next_s.l_wr      = 1'b1;
               next_s.l_wdata   = s.ctrl_copy & ~(8'h01 << CTL_RUN_BIT);
               next_s.fsm       = CS_CLR;
            end else if (s.pend_start || s.pend_timer) begin
               if (s.cfg_n < N_MIN || s.cfg_n > N_MAX) begin          // [R09]
                  next_s.pend_start = 1'b0;
                  next_s.pend_timer = 1'b0;
                  set_ev[ST_BADCFG] = 1'b1;
               end else begin
                  next_s.l_addr  = ADDR_COUNT;                        // [R10]
                  next_s.l_wr    = 1'b1;
                  next_s.l_wdata = s.cfg_d;
                  next_s.fsm     = CS_LOAD_RLD;
               end
            end else if (s.pend_snap) begin
               next_s.pend_snap = 1'b0;
               next_s.l_addr    = ADDR_COUNT;
               next_s.l_rd      = 1'b1;
               next_s.fsm       = CS_READ_WAIT;
            end
         end
         CS_LOAD_RLD: begin
            next_s.l_addr  = ADDR_RELOAD;                             // [R10]
            next_s.l_wr    = 1'b1;
            next_s.l_wdata = s.cfg_d;
            next_s.fsm     = CS_START;
         end
         CS_START: begin
            // Reserved bits stay zero; run and mode go in one write
            next_s.ctrl_copy = 8'h00;                                 // [R13]
            next_s.ctrl_copy[CTL_SEL_LSB +: 2] = 2'(s.cfg_n - 3'h1);  // [R11]
            next_s.ctrl_copy[CTL_RUN_BIT]      = 1'b1;                // [R12]
            next_s.ctrl_copy[CTL_MODE_BIT]     = s.pend_start;        // [R12]
            next_s.l_addr     = ADDR_CTRL;
            next_s.l_wr       = 1'b1;
            next_s.l_wdata    = next_s.ctrl_copy;
            next_s.pend_start = 1'b0;
            next_s.pend_timer = 1'b0;
            set_ev[ST_DONE]   = 1'b1;
            next_s.fsm        = CS_IDLE;
         end
         // Lets the flag clear reach the unit before irq is looked at again
         CS_CLR: next_s.fsm = CS_IDLE;
         CS_READ_WAIT: begin
            if (link.reg_rvalid) begin
               next_s.snap = link.reg_rdata;
               next_s.fsm  = CS_IDLE;
            end
         end
         default: next_s.fsm = CS_IDLE;
      endcase

      // Events win over a same-cycle clear
      next_s.status = next_s.status | set_ev;
      next_s.irq    = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s        <= '0;
         s.fsm    <= CS_IDLE;
         s.cfg_n  <= CFG_N_RST;
         s.wait_r <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.wait_r;
   assign irq             = s.irq;
   assign bit_strobe      = s.bit_strobe;
   assign link.reg_addr   = s.l_addr;
   assign link.reg_wr     = s.l_wr;
   assign link.reg_rd     = s.l_rd;
   assign link.reg_wdata  = s.l_wdata;

endmodule : brg_ctrl

// file: bench/brg_link_checker.sv
// Concurrent checks on the link between the baud rate unit and its controller
`timescale 1ns/1ps
module brg_link_checker (
   input wire logic                        core_clk,
   input wire logic                        rst_b,
   input wire logic [brg_pkg::ADDR_W-1:0]  reg_addr,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [7:0]                  reg_wdata,
   input wire logic [7:0]                  reg_rdata,
   input wire logic                        reg_rvalid,
   input wire logic                        baud_tick,
   input wire logic                        irq,
   input wire logic                        timer_ovf,
   input wire logic [7:0]                  count_now
);
   import brg_pkg::*;

   logic [7:0] reload_sh;
   logic       run_sh;
   logic       wr_ctrl;
   logic       wr_count;

   assign wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_count = reg_wr && (reg_addr == ADDR_COUNT);

   // Shadows of what the controller wrote, so overflow can be judged from the link alone
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reload_sh <= RELOAD_RST;
         run_sh    <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == ADDR_RELOAD)) reload_sh <= reg_wdata;
         if (wr_ctrl) run_sh <= reg_wdata[CTL_RUN_BIT];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_count_readback: assert property (reg_rd && reg_addr == ADDR_COUNT |=>
      reg_rvalid && reg_rdata == $past(count_now)) else $error("count read answer wrong");
   a_ovf_from_top: assert property (timer_ovf |-> $past(count_now) == COUNT_TOP)
      else $error("overflow without full count");
   a_ovf_reloads: assert property (timer_ovf && !$past(wr_count) |-> count_now == $past(reload_sh))
      else $error("counter not reloaded on overflow");
   a_baud_needs_ovf: assert property (baud_tick |-> timer_ovf)
      else $error("baud pulse without overflow");
   a_baud_one_pulse: assert property (baud_tick |=> !baud_tick)
      else $error("baud pulse longer than one cycle");
   a_ovf_sets_flag: assert property (timer_ovf |-> irq)
      else $error("overflow did not set flag");
   a_flag_sticky: assert property (irq && !(wr_ctrl && reg_wdata[CTL_FLAG_BIT]) |=> irq)
      else $error("flag dropped without clear");
   a_flag_clears: assert property (irq && wr_ctrl && reg_wdata[CTL_FLAG_BIT] |=> !irq || timer_ovf)
      else $error("flag not cleared by one");
   a_flag_cause: assert property ($rose(irq) |-> timer_ovf)
      else $error("flag rose without overflow");
   a_stop_holds: assert property (!run_sh && !$past(run_sh) && !$past(wr_count) |-> $stable(count_now))
      else $error("counter moved while stopped");
   a_count_wr_wins: assert property (wr_count |=> count_now == $past(reg_wdata))
      else $error("counter write lost");

endmodule : brg_link_checker

// file: bench/brg_tb_top.sv
// Self-checking bench: controller and baud rate unit joined over the link
`timescale 1ns/1ps
module brg_tb_top;
   import brg_pkg::*;

   localparam logic [7:0] D_VAL  = 8'hfa;
   localparam int         WD_CYC = 60000;

   logic        core_clk;
   logic        rst_b;
   logic [2:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        bit_strobe;
   logic        timer_ovf;
   logic [7:0]  count_now;
   logic [31:0] rd;
   logic [7:0]  held;
   int          err_count;
   int          samples_checked;
   int          g;
   int          n_ovf;
   int          n_baud;

   brg_link_if link ();

   brg_device u_brg_device (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .link      (link),
      .timer_ovf (timer_ovf),
      .count_now (count_now)
   );

   brg_ctrl u_brg_ctrl (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .irq             (irq),
      .bit_strobe      (bit_strobe),
      .link            (link)
   );

   brg_link_checker u_brg_link_checker (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .reg_addr   (link.reg_addr),
      .reg_wr     (link.reg_wr),
      .reg_rd     (link.reg_rd),
      .reg_wdata  (link.reg_wdata),
      .reg_rdata  (link.reg_rdata),
      .reg_rvalid (link.reg_rvalid),
      .baud_tick  (link.baud_tick),
      .irq        (link.irq),
      .timer_ovf  (timer_ovf),
      .count_now  (count_now)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Entered just after a rising edge; request held until waitrequest is seen low
   task automatic av_xfer(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) chk(32'h0, 32'h1, "bus answer");
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // One idle edge so the next request is never raised in the step that released this one
      @(posedge core_clk);
   endtask : av_xfer

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      logic [31:0] q;
      av_xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [2:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      av_xfer(1'b0, a, 32'h0, q);
      chk(q, exp, what);
   endtask : rdchk

   // Cycles between two pulses of the overflow or the bit strobe
   task automatic gap(input logic strobe, output int c);
      int n;
      n = 0;
      while ((strobe ? bit_strobe : timer_ovf) !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while ((strobe ? bit_strobe : timer_ovf) !== 1'b1 && c < 5000);
   endtask : gap

   task automatic wrap_up;
      $display("Checks: %0d  Errors: %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_count       = 0;
      samples_checked = 0;
      rst_b           = 1'b0;
      avs_address     = 3'h0;
      avs_read        = 1'b0;
      avs_write       = 1'b0;
      avs_writedata   = 32'h0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      rdchk(CR_CFG, 32'h100, "cfg after reset");
      rdchk(CR_STATUS, 32'h0, "status after reset");
      rdchk(3'h6, 32'h0, "unmapped read");
      wr(3'h7, 32'hff);
      rdchk(CR_MASK, 32'h0, "mask after unmapped write");
      repeat (40) @(posedge core_clk);
      chk({24'h0, count_now}, 32'h0, "count stopped after reset");
      for (int n = 1; n <= 4; n++) begin
         wr(CR_CFG, (32'(n) << CFG_N_LSB) | {24'h0, D_VAL});
         wr(CR_CMD, 32'h1 << CMD_START);
         repeat (4) @(posedge core_clk);
         av_xfer(1'b0, CR_STATUS, 32'h0, rd);
         chk({31'h0, rd[ST_DONE]}, 32'h1, "setup done");
         wr(CR_STATUS, 32'h1 << ST_DONE);
         gap(1'b0, g);
         chk({31'h0, link.baud_tick}, 32'h1, "baud pulse with overflow");
         gap(1'b0, g);
         chk(32'(g), (32'h2 << (n - 1)) * (32'h100 - D_VAL), "overflow period");
         gap(1'b1, g);
         gap(1'b1, g);
         chk(32'(g), 32'h10 * (32'h2 << (n - 1)) * (32'h100 - D_VAL), "bit time");
         wr(CR_CMD, 32'h1 << CMD_STOP);
         repeat (5) @(posedge core_clk);
      end
      held = count_now;
      repeat (50) @(posedge core_clk);
      chk({24'h0, count_now}, {24'h0, held}, "count held when stopped");
      wr(CR_CMD, 32'h1 << CMD_SNAP);
      repeat (6) @(posedge core_clk);
      rdchk(CR_SNAP, {24'h0, held}, "snapshot of count");
      wr(CR_CFG, (32'h1 << CFG_N_LSB) | {24'h0, D_VAL});
      wr(CR_CMD, 32'h1 << CMD_TIMER);
      repeat (20) @(posedge core_clk);
      n_ovf  = 0;
      n_baud = 0;
      repeat (120) begin
         @(posedge core_clk);
         if (timer_ovf === 1'b1) n_ovf++;
         if (link.baud_tick === 1'b1) n_baud++;
      end
      chk(32'(n_ovf), 32'ha, "timer mode overflows");
      chk(32'(n_baud), 32'h0, "no baud clock in timer mode");
      // Restart while counting, so counter writes meet live increments
      wr(CR_CMD, 32'h1 << CMD_START);
      wr(CR_CMD, 32'h1 << CMD_STOP);
      repeat (8) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(CR_MASK, 32'h1 << ST_OVF);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1, "irq on overflow status");
      wr(CR_STATUS, 32'h1 << ST_OVF);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      // Exponent outside 1..4 must be turned away before it reaches the select field
      wr(CR_CFG, (32'h5 << CFG_N_LSB) | {24'h0, D_VAL});
      wr(CR_CMD, 32'h1 << CMD_START);
      repeat (4) @(posedge core_clk);
      av_xfer(1'b0, CR_STATUS, 32'h0, rd);
      chk({31'h0, rd[ST_BADCFG]}, 32'h1, "bad exponent refused");
      wrap_up();
   end

   initial begin
      repeat (WD_CYC) @(posedge core_clk);
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end

endmodule : brg_tb_top
